// ==== hdl/pcb_bridge.sv ====
// Purpose: command claim and origination policy plus transaction buffers
// Assumes: address phase strobes come from bus logic on i_clock
// Notes: bus reset pins are synchronised; either one flushes every buffer
// Summary of operation
// - two 128-byte write buffers, up and down
// - four further 128-byte buffers for reads
// - interrupt acknowledge never originated nor claimed
// - special cycle originated, never claimed or forwarded
// - reserved codes never originated, left unclaimed
// - io and memory commands both roles, both buses
// - primary master: type 1 config writes only
// - secondary target: type 1 config writes only
// - command taken from enable lines at address phase
`timescale 1ns/1ps
`include "pcb_defs.svh"

module pcb_bridge (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // bus reset pins, active low, asynchronous
   input wire logic i_pri_bus_rst_n,
   input wire logic i_sec_bus_rst_n,
   // primary target address phase
   input wire logic i_pri_addr_phase,
   input wire logic [`PCB_ADDR_W-1:0] i_pri_ad,
   input wire logic [`PCB_CMD_W-1:0] i_primary_cmd_byte_enable_lines,
   // secondary target address phase
   input wire logic i_sec_addr_phase,
   input wire logic [`PCB_ADDR_W-1:0] i_sec_ad,
   input wire logic [`PCB_CMD_W-1:0] i_sec_cmd_byte_enable_lines,
   // claim decisions
   output logic o_pri_claim,
   output logic o_sec_claim,
   // master origination request
   input wire logic i_mst_req,
   input pcb_pkg::pcb_bus_e i_mst_bus,
   input wire logic [`PCB_CMD_W-1:0] i_mst_cmd,
   input wire logic [`PCB_ADDR_W-1:0] i_mst_addr,
   output logic o_mst_accept,
   output logic o_mst_refuse,
   // reset status
   output logic o_pri_in_reset,
   output logic o_sec_in_reset,
   output logic o_flush,
   // buffers: 0 down write, 1 up write, 2 to 5 read
   input wire logic [`PCB_NUM_BUF-1:0] i_buf_push_valid,
   input pcb_pkg::pcb_entry_s [`PCB_NUM_BUF-1:0] i_buf_push_entry,
   output logic [`PCB_NUM_BUF-1:0] o_buf_push_ready,
   output logic [`PCB_NUM_BUF-1:0] o_buf_pop_valid,
   output pcb_pkg::pcb_entry_s [`PCB_NUM_BUF-1:0] o_buf_pop_entry,
   input wire logic [`PCB_NUM_BUF-1:0] i_buf_pop_ready
);
   import pcb_pkg::*;

   // stages of the bus reset synchroniser that are compared
   localparam int SYNC_MID = `PCB_SYNC_STAGES - 2;
   localparam int SYNC_LAST = `PCB_SYNC_STAGES - 1;

   typedef struct packed {
      logic [`PCB_SYNC_STAGES-1:0] pri_sync;
      logic [`PCB_SYNC_STAGES-1:0] sec_sync;
      logic pri_in_reset;
      logic sec_in_reset;
      logic pri_claim;
      logic sec_claim;
      logic mst_accept;
      logic mst_refuse;
   } pcb_bridge_state_s;

   pcb_bridge_state_s state_reg;
   pcb_bridge_state_s state_next;
   logic mst_bus_reset;

   function automatic logic is_type1(input logic [`PCB_ADDR_W-1:0] ad);
      is_type1 = ad[`PCB_CFG_TYPE_MSB:`PCB_CFG_TYPE_LSB] == `PCB_CFG_TYPE1;
   endfunction

   // target side: may this command be claimed on the given bus
   function automatic logic may_claim(input pcb_bus_e bus,
                                      input logic [`PCB_CMD_W-1:0] cmd,
                                      input logic type1);
      unique case (cmd)
         `PCB_CMD_IO_RD, `PCB_CMD_IO_WR, `PCB_CMD_MEM_RD, `PCB_CMD_MEM_WR,
         `PCB_CMD_MEM_RD_MULT, `PCB_CMD_DAC, `PCB_CMD_MEM_RD_LINE,
         `PCB_CMD_MEM_WR_INV: may_claim = 1'b1;
         `PCB_CMD_CFG_RD: may_claim = (bus == PCB_BUS_PRI);
         `PCB_CMD_CFG_WR: may_claim = (bus == PCB_BUS_PRI) || type1;
         // interrupt ack, special cycle and reserved codes
         default: may_claim = 1'b0;
      endcase
   endfunction

   // master side: may this command be driven on the given bus
   function automatic logic may_originate(input pcb_bus_e bus,
                                          input logic [`PCB_CMD_W-1:0] cmd,
                                          input logic type1);
      unique case (cmd)
         `PCB_CMD_IO_RD, `PCB_CMD_IO_WR, `PCB_CMD_MEM_RD, `PCB_CMD_MEM_WR,
         `PCB_CMD_MEM_RD_MULT, `PCB_CMD_DAC, `PCB_CMD_MEM_RD_LINE,
         `PCB_CMD_MEM_WR_INV: may_originate = 1'b1;
         // broadcasts arrive as type 1 writes aimed across the bridge
         `PCB_CMD_SPECIAL: may_originate = 1'b1;
         `PCB_CMD_CFG_RD: may_originate = (bus == PCB_BUS_SEC);
         `PCB_CMD_CFG_WR: may_originate = (bus == PCB_BUS_SEC) || type1;
         default: may_originate = 1'b0;
      endcase
   endfunction

   assign mst_bus_reset = (i_mst_bus == PCB_BUS_PRI) ?
                          state_reg.pri_in_reset : state_reg.sec_in_reset;
   assign o_pri_claim = state_reg.pri_claim;
   assign o_sec_claim = state_reg.sec_claim;
   assign o_mst_accept = state_reg.mst_accept;
   assign o_mst_refuse = state_reg.mst_refuse;
   assign o_pri_in_reset = state_reg.pri_in_reset;
   assign o_sec_in_reset = state_reg.sec_in_reset;
   assign o_flush = state_reg.pri_in_reset || state_reg.sec_in_reset;

   always_comb begin
      state_next = state_reg;
      state_next.pri_sync = {state_reg.pri_sync[SYNC_MID:0], i_pri_bus_rst_n};
      state_next.sec_sync = {state_reg.sec_sync[SYNC_MID:0], i_sec_bus_rst_n};
      // a level counts once the second and third stages agree
      if (state_reg.pri_sync[SYNC_MID] == state_reg.pri_sync[SYNC_LAST]) begin
         state_next.pri_in_reset = !state_reg.pri_sync[SYNC_LAST];
      end
      if (state_reg.sec_sync[SYNC_MID] == state_reg.sec_sync[SYNC_LAST]) begin
         state_next.sec_in_reset = !state_reg.sec_sync[SYNC_LAST];
      end
      // command sampled only in the address phase strobe cycle
      state_next.pri_claim = i_pri_addr_phase && !o_flush &&
         may_claim(PCB_BUS_PRI, i_primary_cmd_byte_enable_lines,
                   is_type1(i_pri_ad));
      state_next.sec_claim = i_sec_addr_phase && !o_flush &&
         may_claim(PCB_BUS_SEC, i_sec_cmd_byte_enable_lines,
                   is_type1(i_sec_ad));
      state_next.mst_accept = i_mst_req && !mst_bus_reset &&
         may_originate(i_mst_bus, i_mst_cmd, is_type1(i_mst_addr));
      state_next.mst_refuse = i_mst_req && !state_next.mst_accept;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_reg.pri_sync <= `PCB_SYNC_RST_VAL;
         state_reg.sec_sync <= `PCB_SYNC_RST_VAL;
         state_reg.pri_in_reset <= 1'b1;
         state_reg.sec_in_reset <= 1'b1;
         state_reg.pri_claim <= 1'b0;
         state_reg.sec_claim <= 1'b0;
         state_reg.mst_accept <= 1'b0;
         state_reg.mst_refuse <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // write buffers first, then read buffers
   for (genvar g = 0; g < `PCB_NUM_BUF; g++) begin : g_buf
      pcb_buffer #(
         .DEPTH(`PCB_BUF_BYTES / `PCB_DWORD_BYTES)
      ) u_buf (
         .i_clock(i_clock),
         .i_rst(i_rst),
         .i_flush(o_flush),
         .i_push_valid(i_buf_push_valid[g]),
         .i_push_entry(i_buf_push_entry[g]),
         .o_push_ready(o_buf_push_ready[g]),
         .o_pop_valid(o_buf_pop_valid[g]),
         .o_pop_entry(o_buf_pop_entry[g]),
         .i_pop_ready(i_buf_pop_ready[g])
      );
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   intack_unclaimed_a: assert property (
      ((i_pri_addr_phase &&
        i_primary_cmd_byte_enable_lines == `PCB_CMD_INTACK) |=> !o_pri_claim)
      and
      ((i_sec_addr_phase &&
        i_sec_cmd_byte_enable_lines == `PCB_CMD_INTACK) |=> !o_sec_claim))
      else $error("interrupt acknowledge claimed");
   intack_refused_a: assert property (
      i_mst_req && i_mst_cmd == `PCB_CMD_INTACK |=> o_mst_refuse)
      else $error("interrupt acknowledge originated");
   special_unclaimed_a: assert property (
      ((i_pri_addr_phase &&
        i_primary_cmd_byte_enable_lines == `PCB_CMD_SPECIAL) |=> !o_pri_claim)
      and
      ((i_sec_addr_phase &&
        i_sec_cmd_byte_enable_lines == `PCB_CMD_SPECIAL) |=> !o_sec_claim))
      else $error("special cycle claimed");
   special_sent_a: assert property (
      i_mst_req && i_mst_cmd == `PCB_CMD_SPECIAL && !mst_bus_reset
      |=> o_mst_accept && !o_mst_refuse)
      else $error("special cycle not originated");
   reserved_unclaimed_a: assert property (
      i_pri_addr_phase && (i_primary_cmd_byte_enable_lines ==
      `PCB_CMD_RSVD_4 || i_primary_cmd_byte_enable_lines == `PCB_CMD_RSVD_9)
      |=> !o_pri_claim)
      else $error("reserved command claimed");
   memory_claimed_a: assert property (
      i_pri_addr_phase && !o_flush &&
      i_primary_cmd_byte_enable_lines == `PCB_CMD_MEM_RD |=> o_pri_claim)
      else $error("memory read not claimed");
   pri_type0_refused_a: assert property (
      i_mst_req && i_mst_bus == PCB_BUS_PRI &&
      i_mst_cmd == `PCB_CMD_CFG_WR && !is_type1(i_mst_addr) |=> o_mst_refuse)
      else $error("type 0 configuration driven on primary");
   sec_cfg_read_a: assert property (
      i_sec_addr_phase && i_sec_cmd_byte_enable_lines == `PCB_CMD_CFG_RD
      |=> !o_sec_claim)
      else $error("configuration read claimed on secondary");
   addr_phase_only_a: assert property (
      !i_pri_addr_phase |=> !o_pri_claim)
      else $error("claim without address phase");
   reset_blocks_a: assert property (
      o_flush |=> !o_pri_claim && !o_sec_claim && o_buf_pop_valid == '0)
      else $error("activity during bus reset");

   pri_claim_c: cover property (o_pri_claim);
   sec_cfg_claim_c: cover property (
      i_sec_addr_phase && i_sec_cmd_byte_enable_lines == `PCB_CMD_CFG_WR
      ##1 o_sec_claim);
   mst_refuse_c: cover property (o_mst_refuse);
   reset_leave_c: cover property ($fell(o_flush));

endmodule

// ==== include/pcb_defs.svh ====
// Purpose: named constants of the bridge command and buffer logic
// Assumes: included by bare name; guarded against double inclusion
// Notes: command codes are the four bits of the address phase
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH

`define PCB_CMD_W 4
`define PCB_ADDR_W 32
`define PCB_DATA_W 32
`define PCB_BE_W 4

`define PCB_CMD_INTACK 4'h0
`define PCB_CMD_SPECIAL 4'h1
`define PCB_CMD_IO_RD 4'h2
`define PCB_CMD_IO_WR 4'h3
`define PCB_CMD_RSVD_4 4'h4
`define PCB_CMD_RSVD_5 4'h5
`define PCB_CMD_MEM_RD 4'h6
`define PCB_CMD_MEM_WR 4'h7
`define PCB_CMD_RSVD_8 4'h8
`define PCB_CMD_RSVD_9 4'h9
`define PCB_CMD_CFG_RD 4'ha
`define PCB_CMD_CFG_WR 4'hb
`define PCB_CMD_MEM_RD_MULT 4'hc
`define PCB_CMD_DAC 4'hd
`define PCB_CMD_MEM_RD_LINE 4'he
`define PCB_CMD_MEM_WR_INV 4'hf

// configuration type sits in the two lowest address bits
`define PCB_CFG_TYPE_LSB 0
`define PCB_CFG_TYPE_MSB 1
`define PCB_CFG_TYPE1 2'h1

`define PCB_BUF_BYTES 128
`define PCB_DWORD_BYTES 4
`define PCB_NUM_WR_BUF 2
`define PCB_NUM_RD_BUF 4
`define PCB_NUM_BUF 6
`define PCB_BUF_DOWN_WR 0
`define PCB_BUF_UP_WR 1
`define PCB_BUF_RD_FIRST 2

`define PCB_SYNC_STAGES 3
`define PCB_SYNC_RST_VAL 3'h0

`endif

// ==== include/pcb_pkg.sv ====
// Purpose: shared types of the bridge command and buffer logic
// Assumes: pcb_defs.svh supplies the widths
// Notes: one buffer entry carries a full address phase plus one dword
`include "pcb_defs.svh"

package pcb_pkg;

   typedef enum logic {
      PCB_BUS_PRI,
      PCB_BUS_SEC
   } pcb_bus_e;

   typedef struct packed {
      logic [`PCB_ADDR_W-1:0] addr;
      logic [`PCB_DATA_W-1:0] data;
      logic [`PCB_CMD_W-1:0] cmd;
      logic [`PCB_BE_W-1:0] be;
   } pcb_entry_s;

endpackage

// ==== hdl/pcb_buffer.sv ====
// Purpose: one transaction buffer holding address, data, command, enables
// Assumes: one clock, synchronous active high reset
// Notes: flush empties the buffer in one cycle and refuses traffic meanwhile
`timescale 1ns/1ps
`include "pcb_defs.svh"

module pcb_buffer #(
   parameter int DEPTH = `PCB_BUF_BYTES / `PCB_DWORD_BYTES
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_flush,
   // fill side
   input wire logic i_push_valid,
   input pcb_pkg::pcb_entry_s i_push_entry,
   output logic o_push_ready,
   // drain side
   output logic o_pop_valid,
   output pcb_pkg::pcb_entry_s o_pop_entry,
   input wire logic i_pop_ready
);
   import pcb_pkg::*;

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   typedef struct packed {
      pcb_entry_s [DEPTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } pcb_buffer_state_s;

   pcb_buffer_state_s state_reg;
   pcb_buffer_state_s state_next;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == LAST) ? '0 : PW'(p + 1'b1);
   endfunction

   assign o_push_ready = !i_flush && (state_reg.count != FULL);
   assign o_pop_valid = !i_flush && (state_reg.count != '0);
   assign o_pop_entry = state_reg.mem[state_reg.rd_ptr];
   assign push = i_push_valid && o_push_ready;
   assign pop = o_pop_valid && i_pop_ready;

   always_comb begin
      state_next = state_reg;
      if (i_flush) begin
         state_next.wr_ptr = '0;
         state_next.rd_ptr = '0;
         state_next.count = '0;
      end else begin
         if (push) begin
            state_next.mem[state_reg.wr_ptr] = i_push_entry;
            state_next.wr_ptr = ptr_inc(state_reg.wr_ptr);
         end
         if (pop) begin
            state_next.rd_ptr = ptr_inc(state_reg.rd_ptr);
         end
         if (push && !pop) begin
            state_next.count = CW'(state_reg.count + 1'b1);
         end else if (pop && !push) begin
            state_next.count = CW'(state_reg.count - 1'b1);
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   full_refuse_a: assert property (
      state_reg.count == FULL |-> !o_push_ready)
      else $error("buffer accepts data while full");
   fill_count_a: assert property (
      push && !pop && !i_flush
      |=> state_reg.count == $past(state_reg.count) + 1)
      else $error("buffer count did not rise on push");
   flush_empty_a: assert property (
      i_flush |=> state_reg.count == '0)
      else $error("buffer not empty after flush");

   buffer_full_c: cover property (state_reg.count == FULL);

endmodule

// ==== verif/pcb_initiator_model.sv ====
// Purpose: far-side initiator that drives address phases onto one bus
// Assumes: bench calls phase at a falling edge of the clock
// Notes: outside an address phase the lines show the inverse of the last
`timescale 1ns/1ps
`include "pcb_defs.svh"

module pcb_initiator_model (
   // clock
   input wire logic i_clock,
   // address phase lines
   output logic o_addr_phase,
   output logic [`PCB_ADDR_W-1:0] o_ad,
   output logic [`PCB_CMD_W-1:0] o_cmd
);
   initial begin
      o_addr_phase = 1'b0;
      o_ad = 32'h0;
      o_cmd = 4'h0;
   end

   // one address phase, command on the enable lines, then release
   task automatic phase(input logic [3:0] cmd, input logic [31:0] ad);
      @(negedge i_clock);
      o_addr_phase = 1'b1;
      o_cmd = cmd;
      o_ad = ad;
      @(negedge i_clock);
      o_addr_phase = 1'b0;
      o_cmd = ~cmd;
      o_ad = ~ad;
   endtask
endmodule

// ==== verif/pcb_bridge_bench.sv ====
// Purpose: self-checking bench of the bridge command and buffer logic
// Assumes: inputs change at the falling edge of a 25 ns clock
// Notes: each buffer is filled until refused, then drained in order
`timescale 1ns/1ps
`include "pcb_defs.svh"

module pcb_bridge_bench;
   import pcb_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic pri_rst_n = 1'b1;
   logic sec_rst_n = 1'b1;
   logic pri_ap, sec_ap, pri_claim, sec_claim, mst_accept, mst_refuse;
   logic [31:0] pri_ad, sec_ad;
   logic [3:0] pri_cmd, sec_cmd;
   logic mst_req = 1'b0;
   pcb_bus_e mst_bus = PCB_BUS_PRI;
   logic [3:0] mst_cmd = 4'h0;
   logic [31:0] mst_addr = 32'h0;
   logic pri_in_rst, sec_in_rst, flush;
   logic [5:0] push_valid = 6'h0;
   logic [5:0] pop_ready = 6'h0;
   logic [5:0] push_ready, pop_valid;
   pcb_entry_s [5:0] push_entry = '0;
   pcb_entry_s [5:0] pop_entry;
   int miscompares = 0;
   int n_compared = 0;

   always #12.5 i_clock = ~i_clock;

   pcb_initiator_model u_pri_init (.i_clock(i_clock),
      .o_addr_phase(pri_ap), .o_ad(pri_ad), .o_cmd(pri_cmd));
   pcb_initiator_model u_sec_init (.i_clock(i_clock),
      .o_addr_phase(sec_ap), .o_ad(sec_ad), .o_cmd(sec_cmd));

   pcb_bridge u_dut (.i_clock(i_clock), .i_rst(i_rst),
      .i_pri_bus_rst_n(pri_rst_n), .i_sec_bus_rst_n(sec_rst_n),
      .i_pri_addr_phase(pri_ap), .i_pri_ad(pri_ad),
      .i_primary_cmd_byte_enable_lines(pri_cmd),
      .i_sec_addr_phase(sec_ap), .i_sec_ad(sec_ad),
      .i_sec_cmd_byte_enable_lines(sec_cmd),
      .o_pri_claim(pri_claim), .o_sec_claim(sec_claim),
      .i_mst_req(mst_req), .i_mst_bus(mst_bus), .i_mst_cmd(mst_cmd),
      .i_mst_addr(mst_addr), .o_mst_accept(mst_accept),
      .o_mst_refuse(mst_refuse), .o_pri_in_reset(pri_in_rst),
      .o_sec_in_reset(sec_in_rst), .o_flush(flush),
      .i_buf_push_valid(push_valid), .i_buf_push_entry(push_entry),
      .o_buf_push_ready(push_ready), .o_buf_pop_valid(pop_valid),
      .o_buf_pop_entry(pop_entry), .i_buf_pop_ready(pop_ready));

   task automatic end_of_test();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [71:0] seen,
                        input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // bounded wait for the flush level
   task automatic wait_flush(input logic lvl);
      int n;
      n = 0;
      while (flush !== lvl && n < 8) begin
         @(negedge i_clock);
         n++;
      end
      if (flush !== lvl) begin
         miscompares++;
         $display("wrong value flush expected %b seen %b", lvl, flush);
         end_of_test();
      end
   endtask

   function automatic logic tgt_ok(input logic sec, input logic [3:0] c,
                                   input logic [1:0] ty);
      case (c)
         4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf: return 1'b1;
         4'ha: return !sec;
         4'hb: return !sec || ty == 2'h1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic mst_ok(input logic sec, input logic [3:0] c,
                                   input logic [1:0] ty);
      case (c)
         4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf: return 1'b1;
         4'ha: return sec;
         4'hb: return sec || ty == 2'h1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic pcb_entry_s mk(input int b, input int i);
      return {32'(b), ~32'(i), 4'(i), 4'(b)};
   endfunction

   task automatic master(input pcb_bus_e b, input logic [3:0] c,
                         input logic [1:0] ty, input logic exp);
      @(negedge i_clock);
      mst_req = 1'b1;
      mst_bus = b;
      mst_cmd = c;
      mst_addr = {30'h2a, ty};
      @(negedge i_clock);
      mst_req = 1'b0;
      check("mst_accept", mst_accept, exp);
      check("mst_refuse", mst_refuse, !exp);
   endtask

   // type 1 writes on the secondary stand for broadcasts sent across
   task automatic target_table();
      logic e;
      for (int c = 0; c < 16; c++) begin
         for (int t = 0; t < 2; t++) begin
            u_pri_init.phase(4'(c), {30'h1234, 2'(t)});
            e = tgt_ok(0, 4'(c), 2'(t));
            check("pri_claim", pri_claim, e);
            u_sec_init.phase(4'(c), {30'h1234, 2'(t)});
            e = tgt_ok(1, 4'(c), 2'(t));
            check("sec_claim", sec_claim, e);
         end
      end
   endtask

   task automatic master_table();
      for (int c = 0; c < 16; c++) begin
         for (int t = 0; t < 2; t++) begin
            master(PCB_BUS_PRI, 4'(c), 2'(t), mst_ok(0, 4'(c), 2'(t)));
            master(PCB_BUS_SEC, 4'(c), 2'(t), mst_ok(1, 4'(c), 2'(t)));
         end
      end
   endtask

   // push one more than fits, then pop every entry back in order
   task automatic fill_drain(input int b);
      for (int i = 0; i <= 32; i++) begin
         @(negedge i_clock);
         push_valid[b] = 1'b1;
         push_entry[b] = mk(b, i);
         check("push_ready", push_ready[b], i < 32);
      end
      for (int i = 0; i < 32; i++) begin
         @(negedge i_clock);
         push_valid[b] = 1'b0;
         pop_ready[b] = 1'b1;
         check("pop_valid", pop_valid[b], 1'b1);
         check("pop_entry", pop_entry[b], mk(b, i));
      end
      @(negedge i_clock);
      pop_ready[b] = 1'b0;
      check("pop_valid", pop_valid[b], 1'b0);
   endtask

   task automatic bus_reset(input logic bus);
      @(negedge i_clock);
      push_valid = 6'h3f;
      @(negedge i_clock);
      push_valid = 6'h0;
      check("pop_valid", pop_valid, 6'h3f);
      pri_rst_n = bus;
      sec_rst_n = !bus;
      wait_flush(1'b1);
      check("in_reset", {pri_in_rst, sec_in_rst}, {!bus, bus});
      check("pop_valid", pop_valid, 6'h0);
      check("push_ready", push_ready, 6'h0);
      u_sec_init.phase(4'h6, 32'h0);
      check("sec_claim", sec_claim, 1'b0);
      master(bus ? PCB_BUS_SEC : PCB_BUS_PRI, 4'h7, 2'h0, 1'b0);
      master(bus ? PCB_BUS_PRI : PCB_BUS_SEC, 4'h7, 2'h0, 1'b1);
      pri_rst_n = 1'b1;
      sec_rst_n = 1'b1;
      wait_flush(1'b0);
      check("pop_valid", pop_valid, 6'h0);
   endtask

   initial begin
      repeat (12) @(negedge i_clock);
      check("flush", flush, 1'b1);
      i_rst = 1'b0;
      wait_flush(1'b0);
      check("in_reset", {pri_in_rst, sec_in_rst}, 2'b00);
      check("push_ready", push_ready, 6'h3f);
      target_table();
      master_table();
      for (int b = 0; b < 6; b++) begin
         fill_drain(b);
      end
      bus_reset(1'b0);
      bus_reset(1'b1);
      end_of_test();
   end
endmodule
